// [cgo_driver.sv]
// one output driver: gating, parking level, polarity and pin format
// assumes: clk_in is already synchronised to mclk; dis_req from mclk logic
`timescale 1ns/100ps

module cgo_driver
    import cgo_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic clk_in,
    input  wire logic dis_req,
    input  wire logic sync_en,
    input  wire logic level,
    input  wire logic diff,
    input  wire logic inv_t,
    input  wire logic inv_c,
    output logic      out_t,
    output logic      out_c,
    output logic      enabled
);

    typedef enum logic [0:0]
    {
        CGO_ST_OFF = 1'b0,
        CGO_ST_ON  = 1'b1
    } cgo_drv_state_t;

    typedef struct packed
    {
        cgo_drv_state_t state;
        logic           clk_prev;
        logic           out_t;
        logic           out_c;
    } cgo_drv_t;

    cgo_drv_t q;
    cgo_drv_t next_q;
    logic     rise;
    logic     may_switch;
    logic     tval;

    ////////////////////////////////////////////////////////////////////////
    // a period is complete at the rising edge that starts the next one
    assign rise       = clk_in & ~q.clk_prev;
    // a stopped divider freezes a synchronous driver in its current state
    assign may_switch = ~sync_en | rise;

    always_comb
    begin
        next_q          = q;
        next_q.clk_prev = clk_in;
        if (may_switch)
        begin
            next_q.state = dis_req ? CGO_ST_OFF : CGO_ST_ON;
        end
        unique case (next_q.state)
            CGO_ST_ON:
            begin
                tval = clk_in ^ inv_t;
            end
            CGO_ST_OFF:
            begin
                tval = level;
            end
        endcase
        next_q.out_t = tval;
        if (diff)
        begin
            next_q.out_c = ~tval;
        end
        else if (next_q.state == CGO_ST_ON)
        begin
            next_q.out_c = clk_in ^ inv_c;
        end
        else
        begin
            next_q.out_c = level;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else if (ce)
        begin
            q <= next_q;
        end
    end

    assign out_t   = q.out_t;
    assign out_c   = q.out_c;
    assign enabled = (q.state == CGO_ST_ON);

    ////////////////////////////////////////////////////////////////////////
    imm_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && !sync_en && dis_req) |=> !enabled)
        else $error("immediate disable did not take effect");

    sync_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && sync_en && !rise) |=> $stable(enabled))
        else $error("synchronous driver switched mid period");

    park_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && !enabled && $past(ce) && $stable(level) && $past(rst_n))
        |-> (out_t == level))
        else $error("disabled driver not parked at its level");

    se_phase_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && !diff && inv_t == inv_c) |=> (out_t == out_c))
        else $error("single-ended pins out of phase by default");

endmodule

// [cgo_output_ctrl.sv]
// clock output gating control: crosspoint, disable sources, twelve drivers
// assumes: divider clocks and alarms come from other clock domains and are
// synchronised here; configuration inputs come from mclk logic
`timescale 1ns/100ps

module cgo_output_ctrl
    import cgo_pkg::*;
#(
    parameter int NUM_DRV = CGO_NUM_DRIVERS,
    parameter int NUM_DIV = CGO_NUM_DIVIDERS,
    parameter int SEL_W   = CGO_SEL_W
)
(
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    input  wire logic [NUM_DIV-1:0]       div_clk,
    input  wire logic                     global_output_disable_pin,
    input  wire logic                     lock_lost,
    input  wire logic                     crystal_signal_lost,
    input  wire logic                     lock_lost_disable_en,
    input  wire logic                     crystal_lost_keep_en,
    input  wire logic                     low_supply_sel,
    input  wire logic [NUM_DRV-1:0]       differential_sel,
    input  wire logic [NUM_DRV*SEL_W-1:0] crosspoint_sel,
    input  wire logic [NUM_DRV-1:0]       true_invert,
    input  wire logic [NUM_DRV-1:0]       complement_invert,
    input  wire logic [NUM_DRV*2-1:0]     single_ended_drive_select,
    input  wire logic [NUM_DRV-1:0]       output_disable,
    input  wire logic [NUM_DRV-1:0]       disable_level_high,
    input  wire logic [NUM_DRV-1:0]       sync_gating_en,
    output logic      [NUM_DRV-1:0]       clock_out_true,
    output logic      [NUM_DRV-1:0]       clock_out_complement,
    output logic      [NUM_DRV-1:0]       driver_enabled,
    output logic      [NUM_DRV*2-1:0]     drive_code,
    output logic      [CGO_CAUSE_W-1:0]   disable_cause
);

    typedef struct packed
    {
        logic [CGO_CAUSE_W-1:0] al1;
        logic [CGO_CAUSE_W-1:0] al2;
        logic [NUM_DIV-1:0]     dv1;
        logic [NUM_DIV-1:0]     dv2;
        logic [NUM_DRV*2-1:0]   code;
        logic [CGO_CAUSE_W-1:0] cause;
    } cgo_ctrl_t;

    cgo_ctrl_t              q;
    cgo_ctrl_t              next_q;
    logic [CGO_CAUSE_W-1:0] gate;
    logic [NUM_DRV-1:0]     dis_req;
    logic [NUM_DRV-1:0]     src_clk;
    logic [NUM_DRV-1:0]     level;
    logic                   pin_s;
    logic                   lock_s;
    logic                   xtal_s;
    logic                   weak_any;
    logic                   none_any;

    ////////////////////////////////////////////////////////////////////////
    // alarm and divider synchronisers; stage one feeds stage two only
    assign pin_s  = q.al2[CGO_CAUSE_PIN];
    assign lock_s = q.al2[CGO_CAUSE_LOCK];
    assign xtal_s = q.al2[CGO_CAUSE_XTAL];

    // causes shared by all drivers
    always_comb
    begin
        gate                 = CGO_RST_CAUSE;
        gate[CGO_CAUSE_PIN]  = pin_s;
        gate[CGO_CAUSE_LOCK] = lock_s & lock_lost_disable_en;
        gate[CGO_CAUSE_XTAL] = xtal_s & ~crystal_lost_keep_en;
    end

    always_comb
    begin
        next_q       = q;
        next_q.al1   = {crystal_signal_lost, lock_lost,
                        global_output_disable_pin};
        next_q.al2   = q.al1;
        next_q.dv1   = div_clk;
        next_q.dv2   = q.dv1;
        next_q.cause = gate;
        for (int i = 0; i < NUM_DRV; i++)
        begin
            // an illegal or unavailable code falls back to the middle one
            unique case (single_ended_drive_select[i*2 +: 2])
                CGO_DRV_NONE:
                begin
                    next_q.code[i*2 +: 2] = CGO_DRV_MID;
                end
                CGO_DRV_WEAK:
                begin
                    next_q.code[i*2 +: 2] = low_supply_sel ? CGO_DRV_MID
                                                           : CGO_DRV_WEAK;
                end
                CGO_DRV_MID:
                begin
                    next_q.code[i*2 +: 2] = CGO_DRV_MID;
                end
                CGO_DRV_STRONG:
                begin
                    next_q.code[i*2 +: 2] = CGO_DRV_STRONG;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else if (ce)
        begin
            q <= next_q;
        end
    end

    assign drive_code    = q.code;
    assign disable_cause = q.cause;

    ////////////////////////////////////////////////////////////////////////
    // crosspoint and per-driver gating
    generate
        for (genvar g = 0; g < NUM_DRV; g++)
        begin : g_drv
            logic [SEL_W-1:0] sel;

            assign sel = crosspoint_sel[g*SEL_W +: SEL_W];
            // an out-of-range selection reads as a stopped clock
            assign src_clk[g] = (int'(sel) < NUM_DIV) ? q.dv2[sel]
                                                      : CGO_RST_LEVEL;
            assign dis_req[g] = |gate | output_disable[g];
            assign level[g]   = disable_level_high[g];

            cgo_driver u_drv
            (
                .mclk    (mclk),
                .rst_n   (rst_n),
                .ce      (ce),
                .clk_in  (src_clk[g]),
                .dis_req (dis_req[g]),
                .sync_en (sync_gating_en[g]),
                .level   (level[g]),
                .diff    (differential_sel[g]),
                .inv_t   (true_invert[g]),
                .inv_c   (complement_invert[g]),
                .out_t   (clock_out_true[g]),
                .out_c   (clock_out_complement[g]),
                .enabled (driver_enabled[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // helper flags for the drive code checks
    always_comb
    begin
        weak_any = 1'b0;
        none_any = 1'b0;
        for (int i = 0; i < NUM_DRV; i++)
        begin
            if (q.code[i*2 +: 2] == CGO_DRV_WEAK)
            begin
                weak_any = 1'b1;
            end
            if (q.code[i*2 +: 2] == CGO_DRV_NONE)
            begin
                none_any = 1'b1;
            end
        end
    end

    global_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && pin_s && sync_gating_en == '0)
        |=> (driver_enabled == '0))
        else $error("global disable pin left a driver on");

    global_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && gate == CGO_RST_CAUSE && output_disable == '0
         && sync_gating_en == '0)
        |=> (driver_enabled == '1))
        else $error("driver off with no disable cause");

    own_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && output_disable[0] && !sync_gating_en[0])
        |=> !driver_enabled[0])
        else $error("own disable bit ignored");

    lock_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && lock_s && lock_lost_disable_en && sync_gating_en == '0)
        |=> (driver_enabled == '0))
        else $error("lock loss did not disable outputs");

    lock_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && lock_s && !lock_lost_disable_en && !pin_s && !xtal_s
         && output_disable == '0 && sync_gating_en == '0)
        |=> (driver_enabled == '1))
        else $error("lock loss disabled outputs by default");

    xtal_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && xtal_s && !crystal_lost_keep_en && sync_gating_en == '0)
        |=> (driver_enabled == '0))
        else $error("crystal loss did not disable outputs");

    xtal_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && xtal_s && crystal_lost_keep_en)
        |=> !disable_cause[CGO_CAUSE_XTAL])
        else $error("keep option ignored on crystal loss");

    drive_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && low_supply_sel) |=> !weak_any && !none_any)
        else $error("unavailable drive code at lowest supply");

    alarm_delay_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && $past(ce) && $past(ce, 2) && $past(rst_n, 2)
         && $past(global_output_disable_pin, 2))
        |-> pin_s)
        else $error("pin disable not seen two cycles later");

endmodule

// [cgo_output_ctrl_tb_top.sv]
// testbench for the clock output gating control
// assumes: divider clocks made here from one counter, all config as ports
`timescale 1ns/100ps

module cgo_output_ctrl_tb_top
    import cgo_pkg::*;
;
    logic        mclk = 0, rst_n = 0, ce = 1, clear = 1;
    logic [6:0]  cnt = '0;
    logic [4:0]  div_clk;
    logic        global_output_disable_pin = 0, lock_lost = 0;
    logic        crystal_signal_lost = 0, lock_lost_disable_en = 0;
    logic        crystal_lost_keep_en = 0, low_supply_sel = 0;
    logic [11:0] differential_sel = 0, true_invert = 0;
    logic [11:0] complement_invert = 0, output_disable = 0;
    logic [11:0] disable_level_high = 0, sync_gating_en = 0;
    logic [35:0] crosspoint_sel;
    logic [23:0] single_ended_drive_select = {12{2'h3}};
    logic [11:0] clock_out_true, clock_out_complement, driver_enabled;
    logic [23:0] drive_code;
    logic [2:0]  disable_cause;
    logic [1:0]  e;
    logic        d;
    logic [11:0] held;
    int          edges [12], min_hi [12];
    int          error_cnt = 0, comparisons = 0, cycles = 0;
    logic [4:0]  cases [6] = '{5'h01, 5'h02, 5'h06, 5'h08, 5'h18, 5'h00};

    cgo_output_ctrl dut (.mclk, .rst_n, .ce, .div_clk,
        .global_output_disable_pin, .lock_lost, .crystal_signal_lost,
        .lock_lost_disable_en, .crystal_lost_keep_en, .low_supply_sel,
        .differential_sel, .crosspoint_sel, .true_invert,
        .complement_invert, .single_ended_drive_select, .output_disable,
        .disable_level_high, .sync_gating_en, .clock_out_true,
        .clock_out_complement, .driver_enabled, .drive_code,
        .disable_cause);
    cgo_rx_model rx (.mclk, .clear, .clk_t(clock_out_true), .edges,
        .min_hi);

    ////////////////////////////////////////////////////////////////////////
    // divider k has a period of 8 << k mclk cycles, slow enough to sync
    initial forever #2 mclk = ~mclk;
    always @(posedge mclk) cnt <= #1 cnt + 7'h01;
    assign div_clk = cnt[6:2];

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            $display("timeout reached");
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task clr;
        clear = 1;
        tick(1);
        clear = 0;
    endtask

    task chk(input string what, input logic [23:0] exp, got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task wait_rise;
        for (int k = 0; k < 300 && clock_out_true[0] !== 1'b0; k++) tick(1);
        for (int k = 0; k < 300 && clock_out_true[0] !== 1'b1; k++) tick(1);
    endtask

    task finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 12; i++) crosspoint_sel[3*i +: 3] = 3'(i % 5);
        tick(10);
        rst_n = 1;
        tick(10);
        clear = 0;
        chk("enabled", 12'hfff, driver_enabled);
        tick(256);
        for (int i = 0; i < 12; i++)
            chk("edges", 24'(256 / (8 << (i % 5))), 24'(edges[i]));
        repeat (16)
        begin
            chk("compl", clock_out_true, clock_out_complement);
            tick(1);
        end
        $display("test default done");

        // a low enable must hold off even an immediate disable
        held = clock_out_true;
        ce = 0;
        output_disable = 12'hfff;
        repeat (8)
        begin
            tick(3);
            chk("frozen", held, clock_out_true);
            chk("frozen en", 12'hfff, driver_enabled);
        end
        ce = 1;
        tick(1);
        chk("at once", 12'h0, driver_enabled);
        output_disable = 0;
        crosspoint_sel[2:0] = 3'h5;
        tick(4);
        repeat (8)
        begin
            chk("stopped", 24'h0, clock_out_true[0]);
            tick(3);
        end
        crosspoint_sel[2:0] = 3'h0;
        $display("test freeze done");

        differential_sel = 12'h0f0;
        true_invert = 12'hf00;
        complement_invert = 12'h003;
        tick(4);
        repeat (16)
        begin
            chk("xor", 12'hff3, clock_out_true ^ clock_out_complement);
            tick(1);
        end
        true_invert = 0;
        complement_invert = 0;
        $display("test format done");

        for (int c = 0; c < 4; c++)
            for (int s = 0; s < 2; s++)
            begin
                single_ended_drive_select = {12{2'(c)}};
                low_supply_sel = s[0];
                tick(2);
                e = (c == 0 || (c == 1 && s == 1)) ? 2'h2 : 2'(c);
                chk("drive", {12{e}}, drive_code);
            end
        $display("test drive done");

        disable_level_high = 12'ha5a;
        foreach (cases[j])
        begin
            {crystal_lost_keep_en, crystal_signal_lost, lock_lost_disable_en,
                lock_lost, global_output_disable_pin} = cases[j];
            tick(6);
            d = cases[j][0] | (cases[j][1] & cases[j][2])
                | (cases[j][3] & ~cases[j][4]);
            chk("enabled", d ? 12'h0 : 12'hfff, driver_enabled);
            chk("cause", {cases[j][3] & ~cases[j][4],
                cases[j][1] & cases[j][2], cases[j][0]}, disable_cause);
            if (d)
            begin
                chk("park t", 12'ha5a, clock_out_true);
                chk("park c", 12'ha5a ^ 12'h0f0, clock_out_complement);
            end
        end
        output_disable = 12'h008;
        tick(2);
        chk("own bit", 12'hff7, driver_enabled);
        output_disable = 0;
        differential_sel = 0;
        disable_level_high = 0;
        $display("test causes done");

        // runt expected: the disable lands in the middle of a high phase
        crosspoint_sel = {12{3'h4}};
        tick(4);
        clr();
        wait_rise();
        tick(8);
        output_disable = 12'hfff;
        tick(1);
        chk("at once", 12'h0, driver_enabled);
        tick(2);
        chk("runt", 1, min_hi[0] < 64);
        output_disable = 0;
        $display("test immediate done");

        sync_gating_en = 12'hfff;
        tick(300);
        clr();
        wait_rise();
        tick(8);
        output_disable = 12'hfff;
        tick(2);
        chk("held on", 12'hfff, driver_enabled);
        for (int k = 0; k < 200 && driver_enabled !== 0; k++) tick(1);
        chk("sync off", 12'h0, driver_enabled);
        tick(2);
        chk("full off", 64, 24'(min_hi[0]));
        clr();
        output_disable = 0;
        tick(2);
        chk("held off", 12'h0, driver_enabled);
        for (int k = 0; k < 200 && driver_enabled !== 12'hfff; k++) tick(1);
        tick(256);
        chk("full on", 64, 24'(min_hi[0]));
        $display("test sync done");

        // synchronisers empty after reset: no divider rise for two edges
        disable_level_high = 12'hfff;
        rst_n = 0;
        tick(2);
        rst_n = 1;
        tick(2);
        chk("park high", 12'hfff, clock_out_true);
        chk("held off", 12'h0, driver_enabled);
        chk("drive", {12{2'h3}}, drive_code);
        $display("test reset done");
        finish_test();
    end
endmodule

// [cgo_pkg.sv]
// constants shared by the clock output gating control and its drivers
// assumes: one core clock; divider clocks arrive as plain sampled levels
package cgo_pkg;

    localparam int CGO_NUM_DRIVERS  = 12;
    localparam int CGO_NUM_DIVIDERS = 5;
    localparam int CGO_SEL_W        = 3;
    localparam int CGO_DRV_W        = 2;

    // single-ended drive strength codes
    localparam logic [1:0] CGO_DRV_NONE   = 2'h0;
    localparam logic [1:0] CGO_DRV_WEAK   = 2'h1;
    localparam logic [1:0] CGO_DRV_MID    = 2'h2;
    localparam logic [1:0] CGO_DRV_STRONG = 2'h3;

    // positions in the alarm synchroniser and cause vectors
    localparam int CGO_CAUSE_W    = 3;
    localparam int CGO_CAUSE_PIN  = 0;
    localparam int CGO_CAUSE_LOCK = 1;
    localparam int CGO_CAUSE_XTAL = 2;

    // reset values
    localparam logic CGO_RST_LEVEL = 1'b0;
    localparam logic [CGO_CAUSE_W-1:0] CGO_RST_CAUSE = 3'h0;

endpackage

// [cgo_rx_model.sv]
// downstream clock receivers: count rising edges, shortest high pulse
// assumes: pins sampled on mclk; clear pulsed by the bench between tests
`timescale 1ns/100ps

module cgo_rx_model
#(
    parameter int N = 12
)
(
    input  wire logic         mclk,
    input  wire logic         clear,
    input  wire logic [N-1:0] clk_t,
    output int                edges [N],
    output int                min_hi [N]
);
    logic [N-1:0] prev = '0;
    logic [N-1:0] seen = '0;
    int           run [N];

    ////////////////////////////////////////////////////////////////////////
    // a run already going at clear is not timed: it would look like a runt
    always @(posedge mclk)
    begin
        for (int i = 0; i < N; i++)
        begin
            if (clear)
            begin
                edges[i] = 0;
                min_hi[i] = 1000;
                seen[i] = 1'b0;
            end
            else if (clk_t[i] && !prev[i])
            begin
                edges[i]++;
                seen[i] = 1'b1;
                run[i] = 1;
            end
            else if (clk_t[i])
                run[i]++;
            else if (prev[i] && seen[i] && run[i] < min_hi[i])
                min_hi[i] = run[i];
        end
        prev = clk_t;
    end
endmodule
